// File: core_exec_pkg.sv
// constants, field layouts, register offsets and state type of the core executor
package core_exec_pkg;

  // widths of the datapath
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int PC_W = 13;
  localparam int MEM_ADDR_W = 7;
  localparam int TARGET_W = 11;
  localparam int LATCH_W = 5;
  localparam int STACK_DEPTH = 8;
  localparam int BUS_ADDR_W = 8;

  // instruction word fields
  localparam int OPC_LSB = 11;
  localparam int OPC_W = 3;
  localparam int DEST_BIT = 7;
  localparam int LATCH_HI_LSB = 3;
  localparam int PC_HI_W = 2;

  // opcodes of the executed subset
  localparam logic [2:0] OPC_NOP = 3'h0;
  localparam logic [2:0] OPC_WATCHDOG_CLEAR = 3'h1;
  localparam logic [2:0] OPC_CALL = 3'h2;
  localparam logic [2:0] OPC_COMPLEMENT = 3'h3;
  localparam logic [2:0] OPC_REG_CLEAR = 3'h4;
  localparam logic [2:0] OPC_ACC_CLEAR = 3'h5;
  localparam logic [2:0] OPC_DECREMENT = 3'h6;
  localparam logic [2:0] OPC_DEC_SKIP_ZERO = 3'h7;

  // register byte offsets
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_ACC = 8'h04;
  localparam logic [7:0] OFF_PC = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_LATCH = 8'h10;
  localparam logic [7:0] OFF_WATCHDOG = 8'h14;
  localparam logic [7:0] OFF_STACK_HEAD = 8'h18;
  localparam logic [7:0] OFF_MEM_ADDR = 8'h1C;
  localparam logic [7:0] OFF_MEM_DATA = 8'h20;

  // status register bit positions, and the prescaler's lowest bit in the watchdog register
  localparam int ST_ZERO_BIT = 0;
  localparam int ST_SLEEP_BIT = 3;
  localparam int ST_EXPIRY_BIT = 4;
  localparam int ST_SKIP_BIT = 8;
  localparam int ST_BUSY_BIT = 9;
  localparam int WATCHDOG_PRESCALE_LSB = 8;

  // values after reset, and the prescaler's top count
  localparam logic RST_ZERO = 1'h0;
  localparam logic RST_EXPIRY = 1'h1;
  localparam logic RST_SLEEP = 1'h1;
  localparam logic [7:0] PRESCALE_MAX = 8'hFF;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // execution state, one-hot
  typedef enum logic [1:0] {
    ST_READY = 2'b01,
    ST_CALL_SECOND = 2'b10
  } exec_state_t;

endpackage : core_exec_pkg

// File: return_stack.sv
// circular return stack holding return addresses pushed by calls
`timescale 1ns/100ps
`default_nettype none
module return_stack
  import core_exec_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH,
  parameter int WIDTH = PC_W
)
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // push side
  input wire logic push,
  input wire logic [WIDTH-1:0] pushData,
  // head of the stack
  output logic [WIDTH-1:0] head
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] slot_reg [DEPTH];
  logic [PTR_W-1:0] ptr_reg;
  logic [PTR_W-1:0] ptr_next;

  // pointer wraps, so the oldest entry is overwritten past DEPTH pushes
  assign ptr_next = ptr_reg + PTR_W'(1);
  assign head = slot_reg[ptr_reg];

  //////////////////////////////////////////////////////////////////////////
  // pointer and storage
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ptr_reg <= '0;
      for (int i = 0; i < DEPTH; i++)
        slot_reg[i] <= '0;
    end
    else if (push)
    begin
      ptr_reg <= ptr_next;
      slot_reg[ptr_next] <= pushData;
    end
  end

endmodule : return_stack
`default_nettype wire

// File: axi_lite_regs_slave.sv
// AXI4-Lite slave turning bus transfers into register strobes
`timescale 1ns/100ps
`default_nettype none
module axi_lite_regs_slave
  import core_exec_pkg::*;
#(
  parameter int ADDR_W = BUS_ADDR_W
)
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // write address channel
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // write data channel
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // write response channel
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read address channel
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // read data channel
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // register side
  output logic wrEn,
  output logic [ADDR_W-1:0] wrAddr,
  output logic [31:0] wrData,
  output logic [3:0] wrStrb,
  input wire logic wrStall,
  input wire logic wrErr,
  output logic [ADDR_W-1:0] rdAddr,
  input wire logic [31:0] rdData,
  input wire logic rdErr
);

  logic awHave_reg;
  logic wHave_reg;
  logic rdPend_reg;

  // commit once both halves are held; a stall keeps the response back
  assign wrEn = awHave_reg && wHave_reg && !bvalid && !wrStall;

  //////////////////////////////////////////////////////////////////////////
  // write address capture
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      awready <= 1'b1;
      awHave_reg <= 1'b0;
      wrAddr <= '0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        wrAddr <= awaddr;
        awHave_reg <= 1'b1;
        awready <= 1'b0;
      end
      else if (wrEn)
        awHave_reg <= 1'b0;
      if (bvalid && bready)
        awready <= 1'b1;
    end
  end

  // write data capture
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wready <= 1'b1;
      wHave_reg <= 1'b0;
      wrData <= '0;
      wrStrb <= '0;
    end
    else
    begin
      if (wvalid && wready)
      begin
        wrData <= wdata;
        wrStrb <= wstrb;
        wHave_reg <= 1'b1;
        wready <= 1'b0;
      end
      else if (wrEn)
        wHave_reg <= 1'b0;
      if (bvalid && bready)
        wready <= 1'b1;
    end
  end

  // write response
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end
    else if (wrEn)
    begin
      bvalid <= 1'b1;
      bresp <= wrErr ? RESP_SLVERR : RESP_OKAY;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // read path: address one cycle, data the next
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      arready <= 1'b1;
      rdPend_reg <= 1'b0;
      rdAddr <= '0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rdAddr <= araddr;
      arready <= 1'b0;
      rdPend_reg <= 1'b1;
    end
    else if (rdPend_reg)
    begin
      rdata <= rdErr ? 32'h0000_0000 : rdData;
      rresp <= rdErr ? RESP_SLVERR : RESP_OKAY;
      rvalid <= 1'b1;
      rdPend_reg <= 1'b0;
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

endmodule : axi_lite_regs_slave
`default_nettype wire

// File: core_instr_exec.sv
// executor for a subset of an 8-bit core's instructions, behind AXI4-Lite
//
// Contract
// - watchdog clear zeroes counter and prescaler
// - watchdog clear sets expiry and sleep flags
// - call pushes program counter plus one
// - call loads target, upper bits from latch
// - call takes two cycles, flags untouched
// - complement inverts register, updates zero flag
// - register clear writes zero, sets zero
// - decrement subtracts one, updates zero flag
// - accumulator clear zeroes it, sets zero
// - decrement-skip stores result, flags untouched
// - zero result discards next instruction
`timescale 1ns/100ps
`default_nettype none
module core_instr_exec
  import core_exec_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // watchdog time base
  input wire logic watchdogTick,
  // write address channel
  input wire logic [BUS_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // write data channel
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // write response channel
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read address channel
  input wire logic [BUS_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // read data channel
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  // byte-lane merge used by every writable register except status and the instruction word
  function automatic logic [31:0] mergeLanes(input logic [31:0] oldVal,
    input logic [31:0] newVal, input logic [3:0] strb);
    logic [31:0] res;
    res = oldVal;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[i*8 +: 8] = newVal[i*8 +: 8];
    return res;
  endfunction : mergeLanes

  logic wrEn;
  logic [BUS_ADDR_W-1:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic wrErr;
  logic [BUS_ADDR_W-1:0] rdAddr;
  logic [31:0] rdData;
  logic rdErr;
  logic [PC_W-1:0] stackHead;
  logic wrStall;

  logic [DATA_W-1:0] acc_reg;
  logic [PC_W-1:0] pc_reg;
  logic [LATCH_W-1:0] latch_reg;
  logic zero_reg;
  logic expiry_reg;
  logic sleep_reg;
  logic skip_reg;
  logic [7:0] watchdog_reg;
  logic [7:0] prescale_reg;
  logic [MEM_ADDR_W-1:0] memAddr_reg;
  logic [DATA_W-1:0] mem_reg [2**MEM_ADDR_W];
  exec_state_t state_reg;

  //////////////////////////////////////////////////////////////////////////
  // bus slave and return stack
  axi_lite_regs_slave #(.ADDR_W(BUS_ADDR_W)) busSlave (
    .clock(clock), .rst(rst),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData), .wrStrb(wrStrb),
    .wrStall(wrStall), .wrErr(wrErr),
    .rdAddr(rdAddr), .rdData(rdData), .rdErr(rdErr)
  );

  logic execValid;
  logic execLive;
  logic [OPC_W-1:0] opcode;
  logic destReg;
  logic [MEM_ADDR_W-1:0] fileAddr;
  logic [TARGET_W-1:0] callTarget;
  logic [DATA_W-1:0] operand;
  logic [DATA_W-1:0] decResult;
  logic [31:0] merged;

  // the second call cycle holds every register write off the bus
  assign wrStall = (state_reg != ST_READY);
  assign execValid = wrEn && (wrAddr == OFF_INSTR);
  assign execLive = execValid && !skip_reg;
  assign opcode = wrData[OPC_LSB +: OPC_W];
  assign destReg = wrData[DEST_BIT];
  assign fileAddr = wrData[MEM_ADDR_W-1:0];
  assign callTarget = wrData[TARGET_W-1:0];
  assign operand = mem_reg[fileAddr];
  assign decResult = operand - DATA_W'(1);

  return_stack #(.DEPTH(STACK_DEPTH), .WIDTH(PC_W)) retStack (
    .clock(clock), .rst(rst),
    .push(execLive && opcode == OPC_CALL),
    .pushData(pc_reg + PC_W'(1)),
    .head(stackHead)
  );

  //////////////////////////////////////////////////////////////////////////
  // register writes from the bus share one merged word
  always_comb
  begin
    merged = 32'h0000_0000;
    case (wrAddr)
      OFF_ACC: merged = mergeLanes(32'(acc_reg), wrData, wrStrb);
      OFF_PC: merged = mergeLanes(32'(pc_reg), wrData, wrStrb);
      OFF_LATCH: merged = mergeLanes(32'(latch_reg), wrData, wrStrb);
      OFF_MEM_ADDR: merged = mergeLanes(32'(memAddr_reg), wrData, wrStrb);
      OFF_MEM_DATA:
        merged = mergeLanes(32'(mem_reg[memAddr_reg]), wrData, wrStrb);
      default: merged = wrData;
    endcase
  end

  // unmapped offsets answer with an error
  always_comb
  begin
    wrErr = 1'b0;
    case (wrAddr)
      OFF_INSTR, OFF_ACC, OFF_PC, OFF_STATUS, OFF_LATCH, OFF_WATCHDOG,
      OFF_STACK_HEAD, OFF_MEM_ADDR, OFF_MEM_DATA: wrErr = 1'b0;
      default: wrErr = 1'b1;
    endcase
  end

  // read mux, reserved bits read as zero
  always_comb
  begin
    rdData = 32'h0000_0000;
    rdErr = 1'b0;
    case (rdAddr)
      OFF_INSTR: rdData = 32'h0000_0000;
      OFF_ACC: rdData = 32'(acc_reg);
      OFF_PC: rdData = 32'(pc_reg);
      OFF_LATCH: rdData = 32'(latch_reg);
      OFF_WATCHDOG: rdData = 32'({prescale_reg, watchdog_reg});
      OFF_STACK_HEAD: rdData = 32'(stackHead);
      OFF_MEM_ADDR: rdData = 32'(memAddr_reg);
      OFF_MEM_DATA: rdData = 32'(mem_reg[memAddr_reg]);
      OFF_STATUS:
      begin
        rdData[ST_ZERO_BIT] = zero_reg;
        rdData[ST_SLEEP_BIT] = sleep_reg;
        rdData[ST_EXPIRY_BIT] = expiry_reg;
        rdData[ST_SKIP_BIT] = skip_reg;
        rdData[ST_BUSY_BIT] = wrStall;
      end
      default: rdErr = 1'b1;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // sequencing: call occupies a second cycle
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      state_reg <= ST_READY;
    else
      case (state_reg)
        ST_READY:
          if (execLive && opcode == OPC_CALL)
            state_reg <= ST_CALL_SECOND;
        ST_CALL_SECOND: state_reg <= ST_READY;
        default: state_reg <= ST_READY;
      endcase
  end

  // discard flag for the instruction after a zero decrement-skip
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      skip_reg <= 1'b0;
    else if (execValid)
      skip_reg <= execLive && opcode == OPC_DEC_SKIP_ZERO
        && decResult == '0;
  end

  // program counter; a discarded slot still advances it
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      pc_reg <= '0;
    else if (execLive && opcode == OPC_CALL)
      pc_reg <= {latch_reg[LATCH_HI_LSB +: PC_HI_W], callTarget};
    else if (execValid)
      pc_reg <= pc_reg + PC_W'(1);
    else if (wrEn && wrAddr == OFF_PC)
      pc_reg <= merged[PC_W-1:0];
  end

  // accumulator
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      acc_reg <= '0;
    else if (execLive)
      case (opcode)
        OPC_COMPLEMENT: if (!destReg) acc_reg <= ~operand;
        OPC_DECREMENT: if (!destReg) acc_reg <= decResult;
        OPC_DEC_SKIP_ZERO:
          if (!destReg) acc_reg <= decResult;
        OPC_ACC_CLEAR: acc_reg <= '0;
        default: acc_reg <= acc_reg;
      endcase
    else if (wrEn && wrAddr == OFF_ACC)
      acc_reg <= merged[DATA_W-1:0];
  end

  // data memory is left unreset, as software must initialise it
  always_ff @(posedge clock)
  begin
    if (execLive)
      case (opcode)
        OPC_COMPLEMENT: if (destReg) mem_reg[fileAddr] <= ~operand;
        OPC_REG_CLEAR: mem_reg[fileAddr] <= '0;
        OPC_DECREMENT, OPC_DEC_SKIP_ZERO:
          if (destReg) mem_reg[fileAddr] <= decResult;
        default: mem_reg[fileAddr] <= operand;
      endcase
    else if (wrEn && wrAddr == OFF_MEM_DATA)
      mem_reg[memAddr_reg] <= merged[DATA_W-1:0];
  end

  // side registers: upper latch and memory window address
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      latch_reg <= '0;
      memAddr_reg <= '0;
    end
    else if (wrEn && wrAddr == OFF_LATCH)
      latch_reg <= merged[LATCH_W-1:0];
    else if (wrEn && wrAddr == OFF_MEM_ADDR)
      memAddr_reg <= merged[MEM_ADDR_W-1:0];
  end

  // zero flag; call and decrement-skip leave it alone
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      zero_reg <= RST_ZERO;
    else if (execLive)
      case (opcode)
        OPC_COMPLEMENT: zero_reg <= (operand == 8'hFF);
        OPC_DECREMENT: zero_reg <= (decResult == '0);
        OPC_REG_CLEAR, OPC_ACC_CLEAR: zero_reg <= 1'b1;
        default: zero_reg <= zero_reg;
      endcase
    else if (wrEn && wrAddr == OFF_STATUS && wrStrb[0])
      zero_reg <= wrData[ST_ZERO_BIT];
  end

  // expiry and sleep flags: the instruction's set wins over a bus clear
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      expiry_reg <= RST_EXPIRY;
      sleep_reg <= RST_SLEEP;
    end
    else if (execLive && opcode == OPC_WATCHDOG_CLEAR)
    begin
      expiry_reg <= 1'b1;
      sleep_reg <= 1'b1;
    end
    else if (wrEn && wrAddr == OFF_STATUS && wrStrb[0])
    begin
      expiry_reg <= expiry_reg & wrData[ST_EXPIRY_BIT];
      sleep_reg <= sleep_reg & wrData[ST_SLEEP_BIT];
    end
  end

  // watchdog prescaler and counter; clearing beats a tick
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      prescale_reg <= '0;
      watchdog_reg <= '0;
    end
    else if (execLive && opcode == OPC_WATCHDOG_CLEAR)
    begin
      prescale_reg <= '0;
      watchdog_reg <= '0;
    end
    else if (watchdogTick)
    begin
      prescale_reg <= prescale_reg + 8'h01;
      if (prescale_reg == PRESCALE_MAX)
        watchdog_reg <= watchdog_reg + 8'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_watchdog_clear_zero: assert property (
    execLive && opcode == OPC_WATCHDOG_CLEAR |=>
      watchdog_reg == 8'h00 && prescale_reg == 8'h00)
    else $error("watchdog not cleared");
  a_status_flags_set: assert property (
    execLive && opcode == OPC_WATCHDOG_CLEAR |=> expiry_reg && sleep_reg
      && $stable(zero_reg))
    else $error("expiry or sleep flag not set");
  a_call_push_return: assert property (
    execLive && opcode == OPC_CALL |=>
      stackHead == $past(pc_reg) + PC_W'(1))
    else $error("wrong return address pushed");
  a_call_target_load: assert property (
    execLive && opcode == OPC_CALL |=>
      pc_reg == {$past(latch_reg[LATCH_HI_LSB +: PC_HI_W]),
      $past(callTarget)})
    else $error("call target wrong");
  a_call_two_cycles: assert property (
    execLive && opcode == OPC_CALL |=> state_reg == ST_CALL_SECOND
      && $stable(zero_reg) && wrStall ##1 state_reg == ST_READY)
    else $error("call not two cycles");
  a_complement_result: assert property (
    execLive && opcode == OPC_COMPLEMENT && !destReg |=>
      acc_reg == ~$past(operand) && zero_reg == ($past(operand) == 8'hFF))
    else $error("complement wrong");
  a_reg_clear_zero: assert property (
    execLive && opcode == OPC_REG_CLEAR |=> zero_reg
      && mem_reg[$past(fileAddr)] == 8'h00)
    else $error("register clear wrong");
  a_decrement_result: assert property (
    execLive && opcode == OPC_DECREMENT && !destReg |=>
      acc_reg == $past(operand) - 8'h01)
    else $error("decrement wrong");
  a_acc_clear_zero: assert property (
    execLive && opcode == OPC_ACC_CLEAR |=> acc_reg == 8'h00 && zero_reg)
    else $error("accumulator clear wrong");
  a_skip_flags_kept: assert property (
    execLive && opcode == OPC_DEC_SKIP_ZERO |=> $stable(zero_reg)
      && $stable(expiry_reg) && $stable(sleep_reg))
    else $error("decrement-skip touched flags");
  a_skip_discards_next: assert property (
    execLive && opcode == OPC_DEC_SKIP_ZERO && operand == 8'h01 |=>
      skip_reg) else $error("skip not armed");
  a_skip_slot_nop: assert property (
    execValid && skip_reg |=> !skip_reg && $stable(acc_reg)
      && $stable(zero_reg)) else $error("discarded slot executed");
  a_single_cycle_exec: assert property (
    execLive && opcode != OPC_CALL |=> state_reg == ST_READY)
    else $error("single-cycle instruction stalled");

  c_call_seen: cover property (execLive && opcode == OPC_CALL);
  c_skip_taken: cover property (skip_reg && execValid);
  c_watchdog_clear: cover property (execLive
    && opcode == OPC_WATCHDOG_CLEAR);
  c_bus_error: cover property (wrEn && wrErr);

endmodule : core_instr_exec
`default_nettype wire

// File: core_instr_exec_subset_bench.sv
// self-checking bench for the instruction executor, driven over AXI4-Lite
`timescale 1ns/100ps
`default_nettype none
module core_instr_exec_subset_bench;
  import core_exec_pkg::*;

  logic clock, rst, watchdogTick;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, lastResp;
  int failures, comparisons;

  core_instr_exec dut_u (.clock(clock), .rst(rst), .watchdogTick(watchdogTick),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));

  ////////////////////////////////////////////////////////////////////////
  // clock at 100 MHz
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // verdict in one place, shared with the watchdog below
  task automatic complete_run;
    if (failures == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  // run needs under a thousand cycles; ten thousand means a hang
  initial
  begin
    #100000;
    failures = failures + 1;
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("[ERR] %0t data got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chkResp(input logic [1:0] got, input logic [1:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("[ERR] %0t response got %h expected %h", $time, got, exp);
    end
  endtask : chkResp

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    lastResp = bresp;
  endtask : wr

  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
    lastResp = rresp;
    chk(rdata, e);
  endtask : rdChk

  function automatic logic [31:0] op(input logic [2:0] c, input logic d,
    input logic [6:0] a);
    return {18'h00000, c, 3'h0, d, a};
  endfunction : op

  // one instruction, then accumulator, memory cell and status
  task automatic step(input logic [31:0] w, input logic [7:0] acc,
    input logic [7:0] mem, input logic [31:0] st);
    wr(OFF_INSTR, w);
    rdChk(OFF_ACC, {24'h000000, acc});
    rdChk(OFF_MEM_DATA, {24'h000000, mem});
    rdChk(OFF_STATUS, st);
  endtask : step

  ////////////////////////////////////////////////////////////////////////
  task automatic testBus;
    rdChk(8'h40, 32'h00000000);
    chkResp(lastResp, RESP_SLVERR);
    wr(8'h44, 32'h000000FF);
    chkResp(lastResp, RESP_SLVERR);
    // only lane 1 lands; a status write without lane 0 is ignored
    @(posedge clock);
    wstrb <= 4'h2;
    wr(OFF_PC, 32'h12345678);
    chkResp(lastResp, RESP_OKAY);
    rdChk(OFF_PC, 32'h00001600);
    wr(OFF_STATUS, 32'h00000000);
    rdChk(OFF_STATUS, 32'h00000018);
    @(posedge clock);
    wstrb <= 4'hF;
  endtask : testBus

  // 257 ticks wrap the prescaler once, so the counter reads one
  task automatic testWatchdog;
    repeat (257)
    begin
      @(posedge clock);
      watchdogTick <= 1'b1;
      @(posedge clock);
      watchdogTick <= 1'b0;
    end
    rdChk(OFF_WATCHDOG, 32'h00000101);
    wr(OFF_STATUS, 32'h00000001);
    rdChk(OFF_STATUS, 32'h00000001);
    wr(OFF_INSTR, op(OPC_WATCHDOG_CLEAR, 1'b0, 7'h00));
    rdChk(OFF_WATCHDOG, 32'h00000000);
    rdChk(OFF_STATUS, 32'h00000019);
  endtask : testWatchdog

  // latch low bits must not leak into the target
  task automatic testCall;
    wr(OFF_LATCH, 32'h0000000F);
    wr(OFF_PC, 32'h00000005);
    wr(OFF_INSTR, {18'h00000, OPC_CALL, 11'h7FF});
    wr(OFF_INSTR, op(OPC_NOP, 1'b0, 7'h00));
    rdChk(OFF_STACK_HEAD, 32'h00000006);
    rdChk(OFF_PC, 32'h00001000);
    rdChk(OFF_STATUS, 32'h00000019);
  endtask : testCall

  // top cell 127, with cell 0 as a bystander
  task automatic testDataOps;
    wr(OFF_MEM_ADDR, 32'h00000000);
    wr(OFF_MEM_DATA, 32'h00000033);
    wr(OFF_MEM_ADDR, 32'h0000007F);
    wr(OFF_MEM_DATA, 32'h00000001);
    wr(OFF_ACC, 32'h00000055);
    wr(OFF_STATUS, 32'h00000018);
    step(op(OPC_DECREMENT, 1'b0, 7'h7F), 8'h00, 8'h01, 32'h19);
    step(op(OPC_DECREMENT, 1'b1, 7'h7F), 8'h00, 8'h00, 32'h19);
    step(op(OPC_DECREMENT, 1'b1, 7'h7F), 8'h00, 8'hFF, 32'h18);
    step(op(OPC_COMPLEMENT, 1'b1, 7'h7F), 8'h00, 8'h00, 32'h19);
    step(op(OPC_COMPLEMENT, 1'b0, 7'h7F), 8'hFF, 8'h00, 32'h18);
    step(op(OPC_ACC_CLEAR, 1'b0, 7'h00), 8'h00, 8'h00, 32'h19);
    wr(OFF_STATUS, 32'h00000018);
    wr(OFF_MEM_DATA, 32'h0000005A);
    step(op(OPC_REG_CLEAR, 1'b1, 7'h7F), 8'h00, 8'h00, 32'h19);
    wr(OFF_MEM_ADDR, 32'h00000000);
    rdChk(OFF_MEM_DATA, 32'h00000033);
  endtask : testDataOps

  // zero flag held low to show the skip leaves it alone
  task automatic testSkip;
    wr(OFF_MEM_ADDR, 32'h0000007F);
    wr(OFF_MEM_DATA, 32'h00000002);
    wr(OFF_ACC, 32'h00000077);
    wr(OFF_PC, 32'h00000010);
    wr(OFF_STATUS, 32'h00000018);
    step(op(OPC_DEC_SKIP_ZERO, 1'b1, 7'h7F), 8'h77, 8'h01, 32'h18);
    step(op(OPC_ACC_CLEAR, 1'b0, 7'h00), 8'h00, 8'h01, 32'h19);
    wr(OFF_ACC, 32'h00000077);
    wr(OFF_STATUS, 32'h00000018);
    step(op(OPC_DEC_SKIP_ZERO, 1'b1, 7'h7F), 8'h77, 8'h00, 32'h118);
    step(op(OPC_ACC_CLEAR, 1'b0, 7'h00), 8'h77, 8'h00, 32'h18);
    step(op(OPC_DEC_SKIP_ZERO, 1'b0, 7'h7F), 8'hFF, 8'h00, 32'h18);
    rdChk(OFF_PC, 32'h00000015);
  endtask : testSkip

  ////////////////////////////////////////////////////////////////////////
  // main sequence: reset for six cycles, then the scenarios
  initial
  begin
    failures = 0;
    comparisons = 0;
    rst = 1'b1;
    watchdogTick = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    wdata = 32'h00000000;
    wstrb = 4'hF;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    rdChk(OFF_STATUS, 32'h00000018);
    testBus();
    testWatchdog();
    testCall();
    testDataOps();
    testSkip();
    complete_run();
  end

endmodule : core_instr_exec_subset_bench
`default_nettype wire
